//--- sfrs_top.sv
// reset sequencer for a serial nor flash: power-on, warm pin reset, soft reset
// assumes cs, sck, si and reset pin come from the host asynchronously
`timescale 1ns/1ns
`include "sfrs_params.svh"
// Function
// - reset pin low during soft reset is ignored
// - pin reset during program or register write flags page as corrupted; soft reset only aborts
// - power-on initialisation runs until power-up delay has elapsed
// - reset pin ignored while power-on initialisation runs
// - pin low at end of power-up holds reset; release after 1.5 ms
// - hardware reset starts only after pin low longer than 200 ns
// - warm reset restores registers like power-on, shorter sequence
// - warm reset lasts 1.5 ms; no selection accepted before that
// - failed power-on makes next pin low rerun full power-on sequence
// - soft reset is arm 66h then execute 99h; a pin low over 200 ns in the same cycle takes priority
module sfrs_top
   import sfrs_pkg::*;
#(
   parameter int unsigned POWER_UP_CYC = `SFRS_POWER_UP_CYC,
   parameter int unsigned WARM_CYC     = `SFRS_WARM_CYC
)
(
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   // host pins
   input  wire logic       cs_n_in,
   input  wire logic       sck_in,
   input  wire logic       si_in,
   input  wire logic       reset_n_in,
   // core status
   input  wire logic       op_busy_in,
   input  wire logic       op_page_write_in,
   input  wire logic       por_fail_in,
   // sequencer outputs
   output logic            ready_out,
   output logic            core_rst_out,
   output logic            op_abort_out,
   output logic            page_corrupt_out,
   output logic            rst_pending_out
);
   localparam logic [`SFRS_CNT_W-1:0] PU_LAST = POWER_UP_CYC[`SFRS_CNT_W-1:0] - 1'b1;
   localparam logic [`SFRS_CNT_W-1:0] WM_LAST = WARM_CYC[`SFRS_CNT_W-1:0] - 1'b1;
   localparam logic [7:0] PULSE_CYC = 8'(`SFRS_PULSE_CYC);
   localparam logic [`SFRS_CNT_W-1:0] SOFT_LAST = `SFRS_CNT_W'(`SFRS_SOFT_RESET_CYC - 1);

   typedef struct packed {
      logic [1:0]            cs_s;
      logic [1:0]            sck_s;
      logic [1:0]            si_s;
      logic [1:0]            rst_s;
      sfrs_state_t           st;
      logic [`SFRS_CNT_W-1:0] cnt;
      logic [7:0]            low_cnt;
      logic                  armed;
      logic                  por_bad;
      logic                  ready;
      logic                  core_rst;
      logic                  abort;
      logic                  corrupt;
      logic                  pending;
   } sfrs_top_t;
   sfrs_top_t s_q, s_d;

   logic       rx_vld;
   logic [7:0] rx_byte;
   logic       pin_low;
   logic       pulse_ok;

   // only stage two of each synchroniser is read
   sfrs_cmd_rx u_rx (
      .clk_in       (clk_in),
      .sys_rst_in   (sys_rst_in),
      .cs_n_in      (s_q.cs_s[1]),
      .sck_in       (s_q.sck_s[1]),
      .si_in        (s_q.si_s[1]),
      .byte_vld_out (rx_vld),
      .byte_out     (rx_byte)
   );

   assign pin_low  = !s_q.rst_s[1];
   assign pulse_ok = pin_low && (s_q.low_cnt >= PULSE_CYC);

   function automatic logic [`SFRS_CNT_W-1:0] cnt_inc(input logic [`SFRS_CNT_W-1:0] c);
      cnt_inc = c + 1'b1;
   endfunction

   always_comb
   begin
      s_d = s_q;
      s_d.cs_s  = {s_q.cs_s[0], cs_n_in};
      s_d.sck_s = {s_q.sck_s[0], sck_in};
      s_d.si_s  = {s_q.si_s[0], si_in};
      s_d.rst_s = {s_q.rst_s[0], reset_n_in};
      s_d.abort = 1'b0;
      // pulse width filter on the pin
      if (!pin_low)
         s_d.low_cnt = 8'h00;
      else if (s_q.low_cnt != 8'hFF)
         s_d.low_cnt = s_q.low_cnt + 8'h01;
      case (s_q.st)
         SFRS_ST_POR:
         begin
            // pin only looked at on the last power-up cycle, power-on owns the device
            s_d.core_rst = 1'b1;
            s_d.cnt = cnt_inc(s_q.cnt);
            if (s_q.cnt == PU_LAST)
            begin
               s_d.cnt = '0;
               s_d.por_bad = por_fail_in;
               s_d.st = pin_low ? SFRS_ST_HOLD : SFRS_ST_READY;
               s_d.ready = !pin_low;
               s_d.core_rst = pin_low;
               s_d.pending = pin_low;
            end
         end
         SFRS_ST_HOLD:
         begin
            // pin still low past power-up or after a pin reset pulse: warm-length hold after release
            if (!pin_low)
            begin
               s_d.cnt = '0;
               s_d.st = SFRS_ST_WARM;
            end
         end
         SFRS_ST_READY:
         begin
            if (rx_vld && rx_byte == `SFRS_CMD_ARM)
               s_d.armed = 1'b1;
            else if (rx_vld && rx_byte == `SFRS_CMD_EXEC && s_q.armed)
            begin
               s_d.armed = 1'b0;
               s_d.cnt = '0;
               s_d.st = SFRS_ST_SOFT;
               s_d.ready = 1'b0;
               s_d.core_rst = 1'b1;
               s_d.abort = op_busy_in;
            end
            else if (rx_vld)
               s_d.armed = 1'b0;
            if (pulse_ok)
            begin
               s_d.armed = 1'b0;
               s_d.cnt = '0;
               s_d.ready = 1'b0;
               s_d.core_rst = 1'b1;
               s_d.pending = 1'b1;
               s_d.abort = op_busy_in;
               s_d.corrupt = s_q.corrupt || (op_busy_in && op_page_write_in);
               // failed power-on reruns the full sequence
               s_d.st = s_q.por_bad ? SFRS_ST_POR : SFRS_ST_HOLD;
            end
         end
         SFRS_ST_WARM:
         begin
            s_d.cnt = cnt_inc(s_q.cnt);
            if (s_q.cnt == WM_LAST)
            begin
               s_d.st = SFRS_ST_READY;
               s_d.ready = 1'b1;
               s_d.core_rst = 1'b0;
               s_d.pending = 1'b0;
               s_d.cnt = '0;
            end
            else if (pulse_ok)
            begin
               // fresh pulse restarts the hold
               s_d.st = SFRS_ST_HOLD;
            end
         end
         SFRS_ST_SOFT:
         begin
            // pin low here is disregarded
            s_d.cnt = cnt_inc(s_q.cnt);
            if (s_q.cnt == SOFT_LAST)
            begin
               s_d.st = SFRS_ST_READY;
               s_d.ready = 1'b1;
               s_d.core_rst = 1'b0;
               s_d.cnt = '0;
            end
         end
         default:
         begin
            s_d.st = SFRS_ST_POR;
            s_d.cnt = '0;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         s_q <= '0;
         s_q.cs_s <= 2'h3;
         s_q.rst_s <= 2'h3;
         s_q.st <= SFRS_ST_POR;
         s_q.core_rst <= 1'b1;
         s_q.pending <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   assign ready_out        = s_q.ready;
   assign core_rst_out     = s_q.core_rst;
   assign op_abort_out     = s_q.abort;
   assign page_corrupt_out = s_q.corrupt;
   assign rst_pending_out  = s_q.pending;

   property p_por_len;
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_POR && s_q.cnt != PU_LAST) |=> !s_q.ready;
   endproperty
   chk_por_no_ready: assert property (p_por_len) else $error("ready during power-on");

   chk_por_pin_ignored: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_POR && s_q.cnt != PU_LAST) |=> s_q.st == SFRS_ST_POR)
      else $error("power-on left early");

   chk_hold_after_low: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_POR && s_q.cnt == PU_LAST && pin_low) |=> s_q.st == SFRS_ST_HOLD)
      else $error("pin low at power-on end not held");

   chk_short_pulse: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_READY && !pulse_ok) |=> s_q.st != SFRS_ST_HOLD)
      else $error("reset on short pulse");

   sequence s_warm_end;
      s_q.st == SFRS_ST_WARM && s_q.cnt == WM_LAST && !pulse_ok;
   endsequence
   chk_warm_done: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      s_warm_end |=> (s_q.ready && !s_q.core_rst))
      else $error("warm reset did not finish");

   chk_warm_busy: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_WARM) |-> !s_q.ready)
      else $error("ready during warm reset");

   chk_soft_pin: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_SOFT && s_q.cnt != SOFT_LAST) |=> s_q.st == SFRS_ST_SOFT)
      else $error("soft reset interrupted");

   chk_soft_start: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_READY && s_q.armed && rx_vld && rx_byte == `SFRS_CMD_EXEC
       && !pulse_ok) |=> s_q.st == SFRS_ST_SOFT)
      else $error("soft reset not started");

   chk_corrupt_set: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_READY && pulse_ok && op_busy_in && op_page_write_in)
      |=> s_q.corrupt)
      else $error("page corruption not flagged");

   chk_por_rerun: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_READY && pulse_ok && s_q.por_bad) |=> s_q.st == SFRS_ST_POR)
      else $error("failed power-on not rerun");

   sequence s_abort_fire;
      s_q.abort;
   endsequence
   chk_abort_single: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      s_abort_fire |=> !s_q.abort)
      else $error("abort longer than one cycle");

   chk_arm_taken: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_READY && rx_vld && rx_byte == `SFRS_CMD_ARM && !pulse_ok)
      |=> s_q.armed)
      else $error("arm command not taken");

   chk_exec_unarmed: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_READY && !s_q.armed && rx_vld && rx_byte == `SFRS_CMD_EXEC)
      |=> s_q.st != SFRS_ST_SOFT)
      else $error("execute without arm accepted");

   chk_hold_stays: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_HOLD && pin_low) |=> (s_q.st == SFRS_ST_HOLD && !s_q.ready))
      else $error("hold left while pin low");

   chk_warm_core_rst: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_WARM) |-> (s_q.core_rst && s_q.pending))
      else $error("core not held during warm reset");

   sequence s_soft_last;
      s_q.st == SFRS_ST_SOFT && s_q.cnt == SOFT_LAST;
   endsequence
   sequence s_back_ready;
      s_q.ready && !s_q.core_rst && s_q.st == SFRS_ST_READY;
   endsequence
   chk_soft_done: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      s_soft_last |=> s_back_ready)
      else $error("soft reset did not finish");

   chk_pulse_start: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.st == SFRS_ST_READY && pulse_ok && !s_q.por_bad)
      |=> (s_q.st == SFRS_ST_HOLD && !s_q.ready && s_q.core_rst && s_q.pending))
      else $error("pin reset not started");
endmodule

//--- sfrs_params.svh
// timing constants and command codes for the flash reset sequencer
// assumes a 250 MHz core clock (4 ns period)
`ifndef SFRS_PARAMS_SVH
`define SFRS_PARAMS_SVH
`define SFRS_CLK_PS                  4000
`define SFRS_POWER_UP_DELAY_US       1750
`define SFRS_WARM_RESET_DURATION_US  1500
`define SFRS_RESET_PULSE_MIN_NS      200
`define SFRS_POWER_UP_CYC   ((`SFRS_POWER_UP_DELAY_US * 1000000) / `SFRS_CLK_PS)
`define SFRS_WARM_CYC       ((`SFRS_WARM_RESET_DURATION_US * 1000000) / `SFRS_CLK_PS)
`define SFRS_PULSE_CYC      (((`SFRS_RESET_PULSE_MIN_NS * 1000) / `SFRS_CLK_PS) + 1)
`define SFRS_SOFT_RESET_CYC  64
`define SFRS_CMD_ARM        8'h66
`define SFRS_CMD_EXEC       8'h99
`define SFRS_CNT_W          20
`endif

//--- sfrs_pkg.sv
// types for the flash reset sequencer
package sfrs_pkg;
   typedef enum logic [4:0] {
      SFRS_ST_POR   = 5'h01,
      SFRS_ST_HOLD  = 5'h02,
      SFRS_ST_READY = 5'h04,
      SFRS_ST_WARM  = 5'h08,
      SFRS_ST_SOFT  = 5'h10
   } sfrs_state_t;
endpackage

//--- sfrs_cmd_rx.sv
// spi mode 0 command byte receiver, first byte of each frame only
// assumes inputs already synchronised to clk_in
`timescale 1ns/1ns
`include "sfrs_params.svh"
module sfrs_cmd_rx
   import sfrs_pkg::*;
(
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   // synchronised link
   input  wire logic       cs_n_in,
   input  wire logic       sck_in,
   input  wire logic       si_in,
   // decoded byte
   output logic            byte_vld_out,
   output logic [7:0]      byte_out
);
   typedef struct packed {
      logic       sck_prev;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic       done;
      logic       vld;
      logic [7:0] data;
   } sfrs_rx_t;
   sfrs_rx_t s_q, s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.vld = 1'b0;
      s_d.sck_prev = sck_in;
      if (cs_n_in)
      begin
         s_d.cnt = 3'h0;
         s_d.done = 1'b0;
      end
      else if (sck_in && !s_q.sck_prev && !s_q.done)
      begin
         s_d.sh = {s_q.sh[6:0], si_in};
         s_d.cnt = s_q.cnt + 3'h1;
         if (s_q.cnt == 3'h7)
         begin
            s_d.done = 1'b1;
            s_d.vld = 1'b1;
            s_d.data = {s_q.sh[6:0], si_in};
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign byte_vld_out = s_q.vld;
   assign byte_out = s_q.data;
endmodule

//--- sfrs_host_model.sv
// host controller model: chip select, serial clock, data and reset pin
// assumes the bench calls its tasks; pins launch 1 ns after clk_in rises
`timescale 1ns/1ns
module sfrs_host_model
(
   // launch clock
   input  wire logic clk_in,
   // host pins
   output logic      cs_n_out,
   output logic      sck_out,
   output logic      si_out,
   output logic      reset_n_out
);
   initial
   begin
      cs_n_out    = 1'b1;
      sck_out     = 1'b0;
      si_out      = 1'b0;
      reset_n_out = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // 64 ns sck, well under the plain read limit; sck still between frames
   task automatic send_frame(input logic [7:0] cmd);
      tick(16);
      cs_n_out = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         si_out = cmd[i];
         tick(8);
         sck_out = 1'b1;
         tick(8);
         sck_out = 1'b0;
      end
      tick(8);
      cs_n_out = 1'b1;
      si_out   = ~si_out;
   endtask
   task automatic pin_pulse(input int cyc);
      tick(1);
      reset_n_out = 1'b0;
      tick(cyc);
      reset_n_out = 1'b1;
      tick(20);
   endtask
   task automatic set_pin(input logic v);
      tick(1);
      reset_n_out = v;
   endtask
endmodule

//--- test_serial_flash_reset_sequencing.sv
// self-checking bench for the flash reset sequencer
// assumes short power-up and warm counts set through the top parameters
`timescale 1ns/1ns
module test_serial_flash_reset_sequencing;
   import sfrs_pkg::*;
   localparam int PU = 200;
   localparam int WM = 100;
   logic clk_in, sys_rst_in, cs_n, sck, si, reset_n, busy, pg_wr, por_fail;
   logic ready, core_rst, op_abort, corrupt, pending;
   int   bad_count, cmp_count, seed, abort_seen, w, r;
   logic [7:0] q[$];
   logic [23:0] tbl [3] = '{24'h000099, 24'h66A599, 24'h006699};
   int   nfr [3] = '{1, 3, 2};
   sfrs_host_model host (.clk_in(clk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si),
                         .reset_n_out(reset_n));
   sfrs_top #(.POWER_UP_CYC(PU), .WARM_CYC(WM)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .cs_n_in(cs_n), .sck_in(sck), .si_in(si), .reset_n_in(reset_n), .op_busy_in(busy),
      .op_page_write_in(pg_wr), .por_fail_in(por_fail), .ready_out(ready),
      .core_rst_out(core_rst), .op_abort_out(op_abort), .page_corrupt_out(corrupt),
      .rst_pending_out(pending));
   initial
   begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
   begin
      if (op_abort === 1'b1) abort_seen++;
   end
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic wait_ready(input int lim);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < lim)
      begin
         host.tick(1);
         n++;
      end
      chk("ready rises in time", ready, 1'b1);
      if (ready !== 1'b1) close_out();
   endtask
   task automatic do_por(input logic pf, input logic pul);
      host.tick(1);
      sys_rst_in = 1'b1;
      por_fail   = pf;
      host.tick(10);
      sys_rst_in = 1'b0;
      host.tick(20);
      if (pul) host.pin_pulse(75);
      host.tick(PU - 10 - (pul ? 117 : 21));
      chk("ready during power-on", ready, 1'b0);
      chk("pending during power-on", pending, 1'b1);
   endtask
   initial
   begin
      {sys_rst_in, busy, pg_wr, por_fail} = 4'h8;
      {bad_count, cmp_count, abort_seen} = 0;
      seed = 32'h1C68;
      repeat (10) @(posedge clk_in);
      do_por(1'b0, 1'b1);
      wait_ready(30);
      $display("test power_on done");
      for (int k = 0; k < 4; k++)
      begin
         r = $random(seed);
         {busy, pg_wr, por_fail} = r[2:0];
         w = 10 + ($unsigned($random(seed)) % 36);
         host.pin_pulse(w);
         chk("ready after short pulse", ready, 1'b1);
         chk("pending after short pulse", pending, 1'b0);
      end
      chk("no abort on short pulse", abort_seen == 0, 1'b1);
      chk("corrupt after short pulse", corrupt, 1'b0);
      $display("test short_pulse done");
      {busy, pg_wr} = 2'h3;
      abort_seen = 0;
      host.pin_pulse(75);
      host.tick(WM - 25);
      chk("ready during warm", ready, 1'b0);
      chk("core reset during warm", core_rst, 1'b1);
      chk("abort pulse seen", abort_seen != 0, 1'b1);
      chk("page corrupt", corrupt, 1'b1);
      {busy, pg_wr} = 2'h0;
      wait_ready(30);
      host.tick(2);
      chk("core reset after warm", core_rst, 1'b0);
      $display("test warm done");
      for (int t = 0; t < 3; t++)
      begin
         q = {};
         for (int f = nfr[t] - 1; f >= 0; f--)
         begin
            q.push_back(tbl[t][8 * f +: 8]);
            host.send_frame(q[$]);
         end
         chk("ready after frames", ready, !(q.size() > 1 && q[$ - 1] == 8'h66 && q[$] == 8'h99));
         wait_ready(80);
         chk("pending after soft", pending, 1'b0);
      end
      $display("test soft_reset done");
      do_por(1'b1, 1'b0);
      wait_ready(30);
      host.pin_pulse(75);
      host.tick(WM + 20);
      chk("ready after failed power-on", ready, 1'b0);
      wait_ready(PU);
      $display("test failed_por done");
      host.set_pin(1'b0);
      do_por(1'b0, 1'b0);
      host.tick(40);
      chk("ready while pin held", ready, 1'b0);
      host.set_pin(1'b1);
      host.tick(WM - 5);
      chk("ready before hold ends", ready, 1'b0);
      wait_ready(30);
      $display("test pin_low_at_power_on done");
      close_out();
   end
endmodule
